// [design/tcpo_timer.sv]
/*
  16-bit timer with two capture/compare channels, pulse generator and one-shot output.
  Assumes control bits arrive as clk-domain levels and one-cycle pulses from software
  logic; edge inputs are asynchronous pins.
*/
`timescale 1ns/1ps
module tcpo_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Edge input pins
  input wire logic edge_input_a,
  input wire logic edge_input_b,
  // Mode control
  input wire logic [1:0] op_mode,
  input wire logic edge_toggle_bit,
  input wire logic overflow_clear,
  // Capture/compare control
  input wire logic cr_a_capture,
  input wire logic cr_a_src_reverse_a,
  input wire logic cr_b_capture,
  // Output control
  input wire logic timer_out_enable,
  input wire logic toggle_on_a,
  input wire logic toggle_on_b,
  input wire logic oneshot_enable,
  input wire logic oneshot_trigger,
  input wire logic level_set,
  input wire logic level_reset,
  // Prescaler and valid-edge selection
  input wire logic [1:0] clock_select,
  input wire logic [1:0] edge_sel_a,
  input wire logic [1:0] edge_sel_b,
  // Channel register writes
  input wire logic ch_a_wr,
  input wire logic ch_b_wr,
  input wire logic [15:0] wr_data,
  // State and events
  output logic [15:0] timer_count,
  output logic [15:0] channel_a_reg,
  output logic [15:0] channel_b_reg,
  output logic overflow_flag,
  output logic timer_output,
  output logic channel_a_irq,
  output logic channel_b_irq
);

  logic [7:0] div_cnt;
  logic [7:0] div_mask;
  logic tick;
  logic running;
  logic a_valid;
  logic a_reverse;
  logic b_valid;
  logic pend_av;
  logic pend_ar;
  logic pend_bv;
  logic pend_sw;
  logic ev_av;
  logic ev_ar;
  logic ev_bv;
  logic ev_sw;
  logic step;
  logic a_compare;
  logic b_compare;
  logic match_a;
  logic match_b;
  logic os_mode;
  logic os_trig;
  logic clear_cnt;
  logic cap_a;
  logic cap_b;
  logic out_level;
  logic next_level;
  tcpo_pkg::tcpo_os_state_t os_state;

  // Input edge detectors
  tcpo_edge_detect u_edge_a (
    .clk(clk),
    .rst_n(rst_n),
    .pin(edge_input_a),
    .edge_sel(edge_sel_a),
    .valid_edge(a_valid),
    .reverse_edge(a_reverse)
  );

  tcpo_edge_detect u_edge_b (
    .clk(clk),
    .rst_n(rst_n),
    .pin(edge_input_b),
    .edge_sel(edge_sel_b),
    .valid_edge(b_valid),
    .reverse_edge()
  );

  // Free-running divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= tcpo_pkg::TCPO_DIV_ZERO;
    end else begin
      div_cnt <= div_cnt + tcpo_pkg::TCPO_DIV_ONE;
    end
  end

  // Count-clock selection
  always_comb begin
    unique case (clock_select)
      tcpo_pkg::TCPO_CLK_DIV1: div_mask = tcpo_pkg::TCPO_MASK_DIV1;
      tcpo_pkg::TCPO_CLK_DIV4: div_mask = tcpo_pkg::TCPO_MASK_DIV4;
      tcpo_pkg::TCPO_CLK_DIV16: div_mask = tcpo_pkg::TCPO_MASK_DIV16;
      tcpo_pkg::TCPO_CLK_DIV256: div_mask = tcpo_pkg::TCPO_MASK_DIV256;
    endcase
  end

  assign tick = (div_cnt & div_mask) == div_mask;
  assign running = op_mode != tcpo_pkg::TCPO_MODE_STOP;
  assign step = tick & running;

  // Events held until the next count clock
  assign ev_av = pend_av | a_valid;
  assign ev_ar = pend_ar | a_reverse;
  assign ev_bv = pend_bv | b_valid;
  assign ev_sw = pend_sw | oneshot_trigger;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_av <= 1'b0;
      pend_ar <= 1'b0;
      pend_bv <= 1'b0;
      pend_sw <= 1'b0;
    end else begin
      pend_av <= running & ~tick & ev_av;
      pend_ar <= running & ~tick & ev_ar;
      pend_bv <= running & ~tick & ev_bv;
      pend_sw <= running & ~tick & ev_sw;
    end
  end

  // Compare and capture decode
  assign a_compare = ~cr_a_capture | (op_mode == tcpo_pkg::TCPO_MODE_PPG);
  assign b_compare = ~cr_b_capture | (op_mode == tcpo_pkg::TCPO_MODE_PPG);
  assign match_a = step & a_compare & (timer_count == channel_a_reg);
  assign match_b = step & b_compare & (timer_count == channel_b_reg);
  assign os_mode = oneshot_enable & ((op_mode == tcpo_pkg::TCPO_MODE_FREE) |
                   (op_mode == tcpo_pkg::TCPO_MODE_EDGE_CLR));
  assign os_trig = step & os_mode & (ev_sw | ev_av);
  assign clear_cnt = os_trig |
                     (step & (op_mode == tcpo_pkg::TCPO_MODE_EDGE_CLR) & ev_av) |
                     (match_a & (op_mode == tcpo_pkg::TCPO_MODE_PPG));
  // Channel A from edge B or reverse phase of edge A
  assign cap_a = step & ~a_compare & (cr_a_src_reverse_a ? ev_ar : ev_bv);
  // Channel B only ever from edge A
  assign cap_b = step & ~b_compare & ev_av;

  // Counter: count up, clear on restart conditions, wrap at maximum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= tcpo_pkg::TCPO_COUNT_ZERO;
    end else if (!running) begin
      timer_count <= tcpo_pkg::TCPO_COUNT_ZERO;
    end else if (clear_cnt) begin
      timer_count <= tcpo_pkg::TCPO_COUNT_ZERO;
    end else if (tick) begin
      timer_count <= timer_count + tcpo_pkg::TCPO_COUNT_ONE;
    end
  end

  // Overflow flag: set wins over software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (step & ~clear_cnt & (timer_count == tcpo_pkg::TCPO_COUNT_MAX)) begin
      overflow_flag <= 1'b1;
    end else if (overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  // Channel A register: capture wins over a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_a_reg <= tcpo_pkg::TCPO_COUNT_ZERO;
    end else if (cap_a) begin
      channel_a_reg <= timer_count;
    end else if (ch_a_wr) begin
      channel_a_reg <= wr_data;
    end
  end

  // Channel B register: capture wins over a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_b_reg <= tcpo_pkg::TCPO_COUNT_ZERO;
    end else if (cap_b) begin
      channel_b_reg <= timer_count;
    end else if (ch_b_wr) begin
      channel_b_reg <= wr_data;
    end
  end

  // Interrupt pulses from matches and captures; channel A capture pulse follows edge B even when A captures on reverse edge A
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_a_irq <= 1'b0;
      channel_b_irq <= 1'b0;
    end else begin
      channel_a_irq <= match_a | (step & ~a_compare & ev_bv);
      channel_b_irq <= match_b | cap_b;
    end
  end

  // One-shot sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      os_state <= tcpo_pkg::TCPO_OS_IDLE;
    end else if (!running || !os_mode) begin
      os_state <= tcpo_pkg::TCPO_OS_IDLE;
    end else if (os_trig) begin
      os_state <= tcpo_pkg::TCPO_OS_DELAY;
    end else begin
      unique case (os_state)
        tcpo_pkg::TCPO_OS_IDLE: os_state <= tcpo_pkg::TCPO_OS_IDLE;
        tcpo_pkg::TCPO_OS_DELAY: begin
          if (match_a) begin
            os_state <= tcpo_pkg::TCPO_OS_ACTIVE;
          end
        end
        tcpo_pkg::TCPO_OS_ACTIVE: begin
          if (match_b) begin
            os_state <= tcpo_pkg::TCPO_OS_IDLE;
          end
        end
      endcase
    end
  end

  // Next output level by mode
  always_comb begin
    next_level = out_level;
    if (!running) begin
      if (level_set) begin
        next_level = 1'b1;
      end else if (level_reset) begin
        next_level = 1'b0;
      end
    end else if (op_mode == tcpo_pkg::TCPO_MODE_PPG) begin
      if (match_a) begin
        next_level = 1'b1;
      end else if (match_b) begin
        next_level = 1'b0;
      end
    end else if (os_mode) begin
      if (!os_trig && os_state == tcpo_pkg::TCPO_OS_DELAY && match_a) begin
        next_level = ~out_level;
      end else if (!os_trig && os_state == tcpo_pkg::TCPO_OS_ACTIVE && match_b) begin
        next_level = ~out_level;
      end
    end else begin
      next_level = out_level ^ (match_a & toggle_on_a) ^ (match_b & toggle_on_b) ^
                   (step & edge_toggle_bit & ev_av);
    end
  end

  // Output level and gated pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_level <= 1'b0;
      timer_output <= 1'b0;
    end else begin
      out_level <= next_level;
      timer_output <= timer_out_enable & next_level;
    end
  end

endmodule

// [include/tcpo_pkg.sv]
/*
  Constants and types for the 16-bit capture / pulse generator / one-shot timer.
  Assumes a single system clock; encodings of control fields are shared with software.
*/
package tcpo_pkg;

  // Counter width and limits
  localparam int TCPO_W = 16;
  localparam logic [15:0] TCPO_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] TCPO_COUNT_ONE = 16'h0001;
  localparam logic [15:0] TCPO_COUNT_MAX = 16'hFFFF;

  // Operating-mode field encodings
  localparam logic [1:0] TCPO_MODE_STOP = 2'h0;
  localparam logic [1:0] TCPO_MODE_FREE = 2'h1;
  localparam logic [1:0] TCPO_MODE_EDGE_CLR = 2'h2;
  localparam logic [1:0] TCPO_MODE_PPG = 2'h3;

  // Valid-edge select encodings
  localparam logic [1:0] TCPO_EDGE_FALL = 2'h0;
  localparam logic [1:0] TCPO_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCPO_EDGE_NONE = 2'h2;
  localparam logic [1:0] TCPO_EDGE_BOTH = 2'h3;

  // Count-clock select encodings
  localparam logic [1:0] TCPO_CLK_DIV1 = 2'h0;
  localparam logic [1:0] TCPO_CLK_DIV4 = 2'h1;
  localparam logic [1:0] TCPO_CLK_DIV16 = 2'h2;
  localparam logic [1:0] TCPO_CLK_DIV256 = 2'h3;

  // Divider masks: tick when the masked divider bits are all ones
  localparam logic [7:0] TCPO_MASK_DIV1 = 8'h00;
  localparam logic [7:0] TCPO_MASK_DIV4 = 8'h03;
  localparam logic [7:0] TCPO_MASK_DIV16 = 8'h0F;
  localparam logic [7:0] TCPO_MASK_DIV256 = 8'hFF;
  localparam logic [7:0] TCPO_DIV_ONE = 8'h01;
  localparam logic [7:0] TCPO_DIV_ZERO = 8'h00;

  // One-shot sequencer states
  typedef enum logic [1:0] {
    TCPO_OS_IDLE,
    TCPO_OS_DELAY,
    TCPO_OS_ACTIVE
  } tcpo_os_state_t;

endpackage

// [design/tcpo_edge_detect.sv]
/*
  Synchroniser and valid-edge detector for one timer input pin.
  Assumes the pin is asynchronous to clk; outputs are one-cycle pulses.
*/
`timescale 1ns/1ps
module tcpo_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edge selection
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  // Detected edges
  output logic valid_edge,
  output logic reverse_edge
);

  logic sync_1;
  logic sync_2;
  logic prev;
  logic rise;
  logic fall;

  // Two-stage synchroniser, then a history flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_1 <= pin;
      sync_2 <= sync_1;
      prev <= sync_2;
    end
  end

  assign rise = sync_2 & ~prev;
  assign fall = ~sync_2 & prev;

  // Edge pulses by selection; reverse phase only for single-edge choices
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_edge <= 1'b0;
      reverse_edge <= 1'b0;
    end else begin
      unique case (edge_sel)
        tcpo_pkg::TCPO_EDGE_FALL: begin
          valid_edge <= fall;
          reverse_edge <= rise;
        end
        tcpo_pkg::TCPO_EDGE_RISE: begin
          valid_edge <= rise;
          reverse_edge <= fall;
        end
        tcpo_pkg::TCPO_EDGE_NONE: begin
          valid_edge <= 1'b0;
          reverse_edge <= 1'b0;
        end
        tcpo_pkg::TCPO_EDGE_BOTH: begin
          valid_edge <= rise | fall;
          reverse_edge <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [test/tcpo_pulse_src.sv]
/*
  Pulse source model for the two timer edge pins.
  Assumes the bench calls its tasks; pins rest low between pulses.
*/
`timescale 1ns/1ps
module tcpo_pulse_src (
  // Edge pins
  output logic edge_input_a,
  output logic edge_input_b
);
  // Pins stay steady unless a pulse is asked for
  initial begin
    edge_input_a = 1'h0;
    edge_input_b = 1'h0;
  end
  // High pulse on pin A, then a quiet gap
  task automatic pulse_a(input int w);
    #3 edge_input_a = 1'h1;
    #w edge_input_a = 1'h0;
    #w;
  endtask
  // High pulse on pin B, then a quiet gap
  task automatic pulse_b(input int w);
    #3 edge_input_b = 1'h1;
    #w edge_input_b = 1'h0;
    #w;
  endtask
endmodule

// [test/tcpo_timer_asserts.sv]
/*
  Port checker for the capture/PPG/one-shot timer.
  Assumes the count clock runs at clk/1 wherever timing is asserted.
*/
`timescale 1ns/1ps
module tcpo_timer_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controls
  input wire logic edge_input_a,
  input wire logic [1:0] op_mode,
  input wire logic [1:0] clock_select,
  input wire logic cr_a_capture,
  input wire logic cr_b_capture,
  input wire logic oneshot_enable,
  input wire logic timer_out_enable,
  input wire logic ch_b_wr,
  // Observed state
  input wire logic [15:0] timer_count,
  input wire logic [15:0] channel_a_reg,
  input wire logic [15:0] channel_b_reg,
  input wire logic overflow_flag,
  input wire logic timer_output,
  input wire logic channel_a_irq,
  input wire logic channel_b_irq
);
  logic [7:0] a_hist;
  logic fr;
  logic ppg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Recent levels of pin A
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_hist <= 8'h00;
    end else begin
      a_hist <= {a_hist[6:0], edge_input_a};
    end
  end
  // Plain free run and PPG on the fastest count clock
  assign fr = op_mode == 2'h1 && clock_select == 2'h0 && !oneshot_enable;
  assign ppg = op_mode == 2'h3 && clock_select == 2'h0;
  sequence ppg_restart;
    ##1 timer_count == 16'h0000 && timer_output == $past(timer_out_enable);
  endsequence
  stop_hold_a: assert property (op_mode == 2'h0 |=>
    timer_count == 16'h0000 && !channel_a_irq && !channel_b_irq) else $error("stop moved");
  count_up_a: assert property (fr && timer_count != 16'hFFFF |=>
    timer_count == $past(timer_count) + 16'h0001) else $error("count step wrong");
  count_wrap_a: assert property (fr && timer_count == 16'hFFFF |=>
    timer_count == 16'h0000 && overflow_flag) else $error("wrap wrong");
  cmp_a_irq_a: assert property (fr && !cr_a_capture && timer_count == channel_a_reg &&
    timer_count != 16'hFFFF |=> channel_a_irq && timer_count != 16'h0000) else $error("cmp a");
  cmp_b_irq_a: assert property (fr && !cr_b_capture && timer_count == channel_b_reg &&
    timer_count != 16'hFFFF |=> channel_b_irq && timer_count != 16'h0000) else $error("cmp b");
  ppg_clear_a: assert property (ppg && timer_count == channel_a_reg |->
    ppg_restart) else $error("ppg restart wrong");
  ppg_low_a: assert property (ppg && timer_count == channel_b_reg |=>
    !timer_output && channel_b_irq) else $error("ppg low wrong");
  cap_b_src_a: assert property ($changed(channel_b_reg) && !$past(ch_b_wr) &&
    clock_select == 2'h0 |-> a_hist != 8'h00 && a_hist != 8'hFF) else $error("b load");
endmodule
bind tcpo_timer tcpo_timer_asserts chk (.clk, .rst_n, .edge_input_a, .op_mode, .clock_select,
  .cr_a_capture, .cr_b_capture, .oneshot_enable, .timer_out_enable, .ch_b_wr, .timer_count,
  .channel_a_reg, .channel_b_reg, .overflow_flag, .timer_output, .channel_a_irq,
  .channel_b_irq);

// [test/tcpo_timer_tb_top.sv]
/*
  Self-checking bench for the capture/PPG/one-shot timer.
  Assumes the pulse source model drives both edge pins.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module tcpo_timer_tb_top;
  logic clk, rst_n, edge_toggle_bit, overflow_clear, cr_a_capture, cr_a_src_reverse_a;
  logic cr_b_capture, timer_out_enable, toggle_on_a, toggle_on_b, oneshot_enable;
  logic oneshot_trigger, level_set, level_reset, ch_a_wr, ch_b_wr, edge_input_a, edge_input_b;
  logic overflow_flag, timer_output, channel_a_irq, channel_b_irq;
  logic [1:0] op_mode, clock_select, edge_sel_a, edge_sel_b;
  logic [15:0] wr_data, timer_count, channel_a_reg, channel_b_reg, c;
  int n_mismatch = 0, compares = 0, cyc = 0, n;
  logic [3:0] hi;
  tcpo_pulse_src src (.edge_input_a, .edge_input_b);
  tcpo_timer DUT (.clk, .rst_n, .edge_input_a, .edge_input_b, .op_mode, .edge_toggle_bit,
    .overflow_clear, .cr_a_capture, .cr_a_src_reverse_a, .cr_b_capture, .timer_out_enable,
    .toggle_on_a, .toggle_on_b, .oneshot_enable, .oneshot_trigger, .level_set, .level_reset,
    .clock_select, .edge_sel_a, .edge_sel_b, .ch_a_wr, .ch_b_wr, .wr_data, .timer_count,
    .channel_a_reg, .channel_b_reg, .overflow_flag, .timer_output, .channel_a_irq,
    .channel_b_irq);
  // Clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounded wait for a level
  task automatic wait_v(ref logic s, input logic v);
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while (s !== v && n < 70000);
    // A wait that runs out is a failure in its own right
    if (s !== v) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Stop, load both channels, then start
  task automatic setup(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk) op_mode <= 2'h0;
    ch_a_wr <= 1'h1;
    wr_data <= a;
    @(posedge clk) ch_a_wr <= 1'h0;
    ch_b_wr <= 1'h1;
    wr_data <= b;
    @(posedge clk) ch_b_wr <= 1'h0;
    op_mode <= m;
  endtask
  task automatic t_compare();
    @(posedge clk) {toggle_on_a, toggle_on_b, timer_out_enable} <= 3'h7;
    setup(2'h1, 16'h0010, 16'h0020);
    wait_v(channel_a_irq, 1'h1);
    `CHK("count at a", 16'h0011, timer_count)
    `CHK("out at a", 1'h1, timer_output)
    wait_v(channel_b_irq, 1'h1);
    `CHK("count at b", 16'h0021, timer_count)
    `CHK("out at b", 1'h0, timer_output)
    $display("compare test done");
  endtask
  task automatic t_capture();
    @(posedge clk) {cr_a_capture, cr_b_capture, edge_toggle_bit} <= 3'h7;
    {toggle_on_a, toggle_on_b, edge_sel_a, edge_sel_b} <= 6'h05;
    setup(2'h1, 16'h0000, 16'h0000);
    repeat (50) @(posedge clk);
    #1 c = timer_count;
    src.pulse_b(200);
    `CHK("b kept", 16'h0000, channel_b_reg)
    `CHK("a from b", 1'h1, 16'(channel_a_reg - c) inside {[2:7]})
    `CHK("out on b", 1'h0, timer_output)
    @(posedge clk) cr_a_src_reverse_a <= 1'h1;
    #1 c = timer_count;
    src.pulse_a(200);
    `CHK("b from a", 1'h1, 16'(channel_b_reg - c) inside {[2:7]})
    `CHK("out on a", 1'h1, timer_output)
    `CHK("a width", 16'h0014, 16'(channel_a_reg - channel_b_reg))
    @(posedge clk) op_mode <= 2'h2;
    repeat (30) @(posedge clk);
    src.pulse_a(100);
    `CHK("restart on a", 1'h1, timer_count inside {[16'h000E:16'h0012]})
    $display("capture test done");
  endtask
  task automatic t_ppg();
    @(posedge clk) {cr_a_capture, cr_b_capture, edge_toggle_bit} <= 3'h0;
    setup(2'h3, 16'h0009, 16'h0003);
    wait_v(timer_output, 1'h0);
    wait_v(timer_output, 1'h1);
    `CHK("ppg clear", 16'h0000, timer_count)
    hi = 4'h0;
    repeat (10) begin
      hi += 4'(timer_output);
      @(posedge clk) #1;
    end
    `CHK("ppg high", 4'h4, hi)
    `CHK("ppg period", 1'h1, timer_output)
    $display("ppg test done");
  endtask
  task automatic t_oneshot();
    @(posedge clk) level_reset <= 1'h1;
    setup(2'h1, 16'h0005, 16'h000C);
    repeat (30) @(posedge clk);
    {level_reset, oneshot_trigger} <= 2'h1;
    @(posedge clk) oneshot_trigger <= 1'h0;
    #1 `CHK("off ignores", 1'h1, timer_count > 16'h0010)
    @(posedge clk) oneshot_enable <= 1'h1;
    @(posedge clk) oneshot_trigger <= 1'h1;
    @(posedge clk) oneshot_trigger <= 1'h0;
    wait_v(timer_output, 1'h1);
    `CHK("os delay", 6, n)
    wait_v(timer_output, 1'h0);
    `CHK("os width", 7, n)
    repeat (30) @(posedge clk);
    #1 `CHK("os single", 1'h0, timer_output)
    @(posedge clk) oneshot_enable <= 1'h0;
    $display("one-shot test done");
  endtask
  task automatic t_prescale();
    @(posedge clk) clock_select <= 2'h1;
    setup(2'h1, 16'h0100, 16'h0200);
    repeat (40) @(posedge clk);
    #1 `CHK("div4 count", 16'h000A, timer_count)
    @(posedge clk) clock_select <= 2'h0;
    $display("prescale test done");
  endtask
  task automatic t_wrap();
    setup(2'h1, 16'h1234, 16'h2345);
    wait_v(overflow_flag, 1'h1);
    `CHK("wrap", 16'h0000, timer_count)
    @(posedge clk) overflow_clear <= 1'h1;
    @(posedge clk) overflow_clear <= 1'h0;
    #1 `CHK("ovf clear", 1'h0, overflow_flag)
    $display("wrap test done");
  endtask
  // Main sequence
  initial begin
    {rst_n, edge_toggle_bit, overflow_clear, cr_a_capture, cr_a_src_reverse_a} = '0;
    {cr_b_capture, timer_out_enable, toggle_on_a, toggle_on_b, oneshot_enable} = '0;
    {oneshot_trigger, level_set, level_reset, ch_a_wr, ch_b_wr} = '0;
    {op_mode, clock_select, edge_sel_a, edge_sel_b, wr_data} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (5) @(posedge clk);
    #1 `CHK("stopped", 16'h0000, timer_count)
    t_compare();
    t_capture();
    t_ppg();
    t_oneshot();
    t_prescale();
    t_wrap();
    tally_and_finish();
  end
endmodule
